/* design/tcq_crossbar.sv */
// transfer crossbar: chain node, miss requester, queues, working sets
// assumes ports, requestors and chain all run on sys_clk
`timescale 1ns/1ps
`default_nettype none
module tcq_crossbar
  import tcq_pkg::*;
#(
  parameter int DEPTH = 4
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic chain_valid,
  output logic chain_ready,
  input wire logic token_held,
  input wire logic [1:0] chain_prio,
  input wire logic [31:0] chain_src,
  input wire logic [31:0] chain_dst,
  input wire logic [15:0] chain_count,
  input wire logic chain_src_incr,
  input wire logic chain_dst_incr,
  input wire logic miss_valid,
  output logic miss_ready,
  input wire logic miss_write,
  input wire logic miss_dirty,
  input wire logic miss_sram,
  input wire logic miss_program,
  input wire logic [31:0] miss_addr,
  input wire logic [31:0] miss_l2_addr,
  input wire logic [31:0] miss_evict_addr,
  output logic cpu_release,
  output logic write_merge,
  output logic pw_valid,
  output logic [1:0] pw_port,
  output logic [31:0] pw_addr,
  output logic [15:0] pw_len,
  output logic [1:0] pw_queue,
  input wire logic ack_valid,
  input wire logic [1:0] ack_queue,
  output logic rc_valid,
  output logic [1:0] rc_port,
  output logic [31:0] rc_addr,
  output logic [15:0] rc_len,
  output logic [1:0] rc_queue,
  input wire logic [NP-1:0] rd_valid,
  output logic [NP-1:0] rd_ready,
  input wire logic [NP-1:0][31:0] rd_data,
  input wire logic [NP-1:0][1:0] rd_queue,
  output logic wr_valid,
  output logic [1:0] wr_port,
  output logic [31:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [1:0] wr_queue,
  output logic wr_last,
  output logic xfer_done,
  output logic [1:0] xfer_done_queue
);
  localparam int PW = $clog2(DEPTH);
  // ==========================================================
  // miss requester
  tcq_miss_type mst_q;
  logic [31:0] m_addr_q, m_l2_q, m_ev_q;
  logic m_wr_q, m_sram_q, m_prog_q;
  logic loc_valid, loc_take, sel_local;
  logic [31:0] loc_src, loc_dst, mask, ext_base, l2_base;
  logic [15:0] loc_count, line_b, fo, fl, so;
  logic [1:0] loc_tag, qtr;

  assign miss_ready = (mst_q == M_IDLE);
  assign loc_valid = (mst_q != M_IDLE);
  assign qtr = m_addr_q[6:5];
  assign line_b = m_sram_q ? (m_prog_q ? L1P_LINE : L1D_LINE) : L2_LINE;
  assign mask = ~({16'h0, line_b} - 32'h1);
  assign ext_base = m_addr_q & mask;
  assign l2_base = m_l2_q & mask;
  // first piece starts at the missed quarter, quarter one takes a half
  // a first-level line in all-SRAM mode always starts at its base
  assign fo = m_sram_q ? 16'h0 : {9'h0, qtr, 5'h0};
  assign fl = (qtr == 2'h0) ? HALF_LINE : L2_LINE - fo;
  assign so = (qtr == 2'h0) ? HALF_LINE : 16'h0;

  // request built from the sequencer state
  always_comb begin
    loc_src = '0;
    loc_dst = '0;
    loc_count = '0;
    loc_tag = TAG_NONE;
    unique case (mst_q)
      M_IDLE: begin
      end
      M_EVICT: begin
        loc_src = l2_base;
        loc_dst = m_ev_q & mask;
        loc_count = {2'h0, line_b[15:2]};
      end
      M_FIRST: begin
        loc_src = ext_base + {16'h0, fo};
        loc_dst = l2_base + {16'h0, fo};
        loc_count = m_sram_q ? {2'h0, line_b[15:2]} : {2'h0, fl[15:2]};
        loc_tag = m_wr_q ? TAG_WR_MISS : TAG_RD_MISS;
      end
      M_SECOND: begin
        loc_src = ext_base + {16'h0, so};
        loc_dst = l2_base + {16'h0, so};
        loc_count = (L2_LINE - fl) >> 2;
      end
    endcase
  end

  // eviction goes first so the victim leaves before the fill lands
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      mst_q <= M_IDLE;
      m_addr_q <= '0;
      m_l2_q <= '0;
      m_ev_q <= '0;
      m_wr_q <= 1'b0;
      m_sram_q <= 1'b0;
      m_prog_q <= 1'b0;
    end else begin
      unique case (mst_q)
        M_IDLE: if (miss_valid) begin
          m_addr_q <= miss_addr;
          m_l2_q <= miss_l2_addr;
          m_ev_q <= miss_evict_addr;
          m_wr_q <= miss_write;
          m_sram_q <= miss_sram;
          m_prog_q <= miss_program;
          mst_q <= miss_dirty ? M_EVICT : M_FIRST;
        end
        M_EVICT: if (loc_take) mst_q <= M_FIRST;
        M_FIRST: if (loc_take) mst_q <= m_sram_q ? M_IDLE : M_SECOND;
        M_SECOND: if (loc_take) mst_q <= M_IDLE;
      endcase
    end
  end

  // ==========================================================
  // last chain node and queue entry
  logic [1:0] in_q;
  logic [ENT_W-1:0] in_ent;
  logic [NQ-1:0] full;
  logic in_ok;
  // local cache requests wait behind the chain unless token is here
  assign sel_local = loc_valid && (!chain_valid || token_held);
  assign in_q = sel_local ? Q_URGENT :
    ((chain_prio == 2'h3) ? Q_LOW : chain_prio);
  assign in_ent = sel_local ?
    {loc_tag, 1'b1, 1'b1, loc_count, loc_dst, loc_src} :
    {TAG_NONE, chain_src_incr, chain_dst_incr, chain_count, chain_dst,
     chain_src};
  assign in_ok = (sel_local || chain_valid) && !full[in_q];
  assign loc_take = sel_local && in_ok;
  assign chain_ready = !sel_local && !full[in_q];

  // ==========================================================
  // queues and working register sets, one per priority
  logic [NQ-1:0] want_pw, want_rc, want_wr, done_v;
  logic [31:0] src_a [NQ];
  logic [31:0] dst_a [NQ];
  logic [15:0] blen_a [NQ];
  logic [15:0] bl_a [NQ];
  logic [1:0] tag_a [NQ];
  logic [15:0] beat_a [NQ];
  logic [1:0] pw_gnt, rc_gnt, wr_sel;
  logic pw_valid_d, rc_valid_d, wr_any;
  logic last_beat;

  for (genvar q = 0; q < NQ; q++) begin : g_q
    logic [ENT_W-1:0] mem [DEPTH];
    logic [ENT_W-1:0] head;
    logic [PW-1:0] wp_q, rp_q;
    logic [PW:0] n_q;
    logic push, pop, hit;
    tcq_ws_type st_q;
    logic [31:0] src_q, dst_q;
    logic [15:0] rem_q, beat_q, blen_q, lim, blen;
    logic sinc_q, dinc_q;
    logic [1:0] tag_q, sp, dp;

    assign push = in_ok && (in_q == q[1:0]);
    assign pop = (st_q == W_IDLE) && (n_q != '0);
    assign full[q] = (n_q == (PW+1)'(DEPTH));
    assign head = mem[rp_q];
    assign sp = src_q[31:30];
    assign dp = dst_q[31:30];
    // second-level memory returns all ones, so the other side rules
    assign lim = (tcq_burst_of(sp) < tcq_burst_of(dp)) ?
      tcq_burst_of(sp) : tcq_burst_of(dp);
    assign blen = (rem_q < lim) ? rem_q : lim;
    assign want_pw[q] = (st_q == W_PREWR);
    assign want_rc[q] = (st_q == W_READ);
    assign want_wr[q] = (st_q == W_XFER) && rd_valid[sp] &&
      (rd_queue[sp] == q[1:0]);
    assign hit = want_wr[q] && (wr_sel == q[1:0]);
    assign done_v[q] = hit && last_beat && (rem_q == blen_q);
    assign src_a[q] = src_q;
    assign dst_a[q] = dst_q;
    assign blen_a[q] = blen;
    assign bl_a[q] = blen_q;
    assign tag_a[q] = tag_q;
    assign beat_a[q] = beat_q;

    // fifo storage; depth must be a power of two for pointer wrap
    always_ff @(posedge sys_clk) begin
      if (push) mem[wp_q] <= in_ent;
    end

    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        wp_q <= '0;
        rp_q <= '0;
        n_q <= '0;
      end else begin
        if (push) wp_q <= wp_q + 1'b1;
        if (pop) rp_q <= rp_q + 1'b1;
        n_q <= n_q + (PW+1)'(push) - (PW+1)'(pop);
      end
    end

    // write-driven sequence: pre-write, acknowledge, read, write beats
    always_ff @(posedge sys_clk) begin
      if (!resetn) begin
        st_q <= W_IDLE;
        src_q <= '0;
        dst_q <= '0;
        rem_q <= '0;
        beat_q <= '0;
        blen_q <= '0;
        sinc_q <= 1'b0;
        dinc_q <= 1'b0;
        tag_q <= TAG_NONE;
      end else begin
        unique case (st_q)
          W_IDLE: if (pop) begin
            {tag_q, sinc_q, dinc_q, rem_q, dst_q, src_q} <= head;
            st_q <= (head[79:64] == 16'h0) ? W_IDLE : W_PREWR;
          end
          W_PREWR: if (pw_valid_d && pw_gnt == q[1:0]) begin
            beat_q <= blen;
            blen_q <= blen;
            st_q <= W_ACK;
          end
          W_ACK: if (ack_valid && ack_queue == q[1:0]) st_q <= W_READ;
          W_READ: if (rc_valid_d && rc_gnt == q[1:0]) begin
            if (sinc_q) src_q <= src_q + {14'h0, blen_q, 2'h0};
            st_q <= W_XFER;
          end
          W_XFER: if (hit) begin
            beat_q <= beat_q - 16'h1;
            if (dinc_q) dst_q <= dst_q + ELEM_BYTES;
            if (last_beat) begin
              rem_q <= rem_q - blen_q;
              st_q <= (rem_q == blen_q) ? W_IDLE : W_PREWR;
            end
          end
        endcase
      end
    end

    a_read_after_ack: assert property (@(posedge sys_clk) disable iff (!resetn)
      (st_q == W_READ && $past(st_q) == W_ACK) |->
        $past(ack_valid && ack_queue == q[1:0]))
      else $error("read raised without acknowledge");
    a_burst_in_rem: assert property (@(posedge sys_clk) disable iff (!resetn)
      (st_q == W_PREWR) |-> (blen <= rem_q && blen != 16'h0))
      else $error("burst longer than remaining count");
  end

  // ==========================================================
  // command pipelines, fixed priority every cycle
  assign pw_valid_d = |want_pw;
  assign rc_valid_d = |want_rc;
  assign wr_any = |want_wr;
  assign pw_gnt = tcq_first(want_pw);
  assign rc_gnt = tcq_first(want_rc);
  assign wr_sel = tcq_first(want_wr);
  assign last_beat = (bl_a[wr_sel] == 16'h0) ? 1'b0 :
    (beat_a[wr_sel] == 16'h1);

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pw_valid <= 1'b0;
      pw_port <= '0;
      pw_addr <= '0;
      pw_len <= '0;
      pw_queue <= '0;
      rc_valid <= 1'b0;
      rc_port <= '0;
      rc_addr <= '0;
      rc_len <= '0;
      rc_queue <= '0;
    end else begin
      pw_valid <= pw_valid_d;
      pw_queue <= pw_gnt;
      pw_addr <= dst_a[pw_gnt];
      pw_port <= dst_a[pw_gnt][31:30];
      pw_len <= blen_a[pw_gnt];
      rc_valid <= rc_valid_d;
      rc_queue <= rc_gnt;
      rc_addr <= src_a[rc_gnt];
      rc_port <= src_a[rc_gnt][31:30];
      rc_len <= bl_a[rc_gnt];
    end
  end

  // ==========================================================
  // routing unit onto the shared write bus
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      rd_ready[p] = wr_any && (src_a[wr_sel][31:30] == p[1:0]);
    end
  end

  // one beat per cycle; queues interleave beat by beat
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wr_valid <= 1'b0;
      wr_port <= '0;
      wr_addr <= '0;
      wr_data <= '0;
      wr_queue <= '0;
      wr_last <= 1'b0;
    end else begin
      wr_valid <= wr_any;
      wr_queue <= wr_sel;
      wr_addr <= dst_a[wr_sel];
      wr_port <= dst_a[wr_sel][31:30];
      wr_data <= rd_data[src_a[wr_sel][31:30]];
      wr_last <= wr_any && last_beat;
    end
  end

  // completion pulses; only the first miss fetch carries a tag
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      xfer_done <= 1'b0;
      xfer_done_queue <= '0;
      cpu_release <= 1'b0;
      write_merge <= 1'b0;
    end else begin
      xfer_done <= |done_v;
      xfer_done_queue <= wr_sel;
      cpu_release <= (|done_v) && tag_a[wr_sel] == TAG_RD_MISS;
      write_merge <= (|done_v) && tag_a[wr_sel] == TAG_WR_MISS;
    end
  end

  // ==========================================================
  // checks
  a_serial_burst: assert property (@(posedge sys_clk) disable iff (!resetn)
    (pw_valid && pw_port == P_SERIAL) |-> pw_len == 16'h1)
    else $error("serial port burst not one");
  a_pw_urgent: assert property (@(posedge sys_clk) disable iff (!resetn)
    want_pw[0] |=> (pw_valid && pw_queue == Q_URGENT))
    else $error("urgent pre-write not granted first");
  a_write_from_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    wr_valid |-> $past(|(rd_valid & rd_ready)))
    else $error("write without read data");
  a_chain_first: assert property (@(posedge sys_clk) disable iff (!resetn)
    (chain_valid && loc_valid && !token_held) |-> !loc_take)
    else $error("local request beat chain request");
  a_cache_urgent: assert property (@(posedge sys_clk) disable iff (!resetn)
    loc_take |-> in_q == Q_URGENT)
    else $error("cache request outside urgent queue");
  a_quarter_two: assert property (@(posedge sys_clk) disable iff (!resetn)
    (miss_valid && miss_ready && !miss_sram && !miss_dirty &&
     miss_addr[6:5] == 2'h1) |=> (loc_count == 16'h0018 && loc_tag != 2'h0))
    else $error("second quarter first piece not 96 bytes");
endmodule
`default_nettype wire

/* inc/tcq_pkg.sv */
// constants, types and helpers for the transfer crossbar
// assumes elements are 32-bit words and ports are picked by address bits
package tcq_pkg;
  // ==========================================================
  // sizes
  localparam int NQ = 3;
  localparam int NP = 4;
  localparam int ENT_W = 84;
  // queue indices, lower index has higher priority
  localparam logic [1:0] Q_URGENT = 2'h0;
  localparam logic [1:0] Q_HIGH = 2'h1;
  localparam logic [1:0] Q_LOW = 2'h2;
  // ports decoded from address bits 31:30
  localparam logic [1:0] P_L2 = 2'h0;
  localparam logic [1:0] P_SERIAL = 2'h1;
  localparam logic [1:0] P_HOST = 2'h2;
  localparam logic [1:0] P_EXTMEM = 2'h3;
  // ==========================================================
  // burst lengths in elements; second-level memory has no limit
  localparam logic [15:0] BURST_EXTMEM = 16'h0004;
  localparam logic [15:0] BURST_SERIAL = 16'h0001;
  localparam logic [15:0] BURST_HOST = 16'h0004;
  localparam logic [15:0] BURST_L2 = 16'hFFFF;
  localparam logic [31:0] ELEM_BYTES = 32'h0000_0004;
  // line sizes in bytes
  localparam logic [15:0] L2_LINE = 16'h0080;
  localparam logic [15:0] L1P_LINE = 16'h0100;
  localparam logic [15:0] L1D_LINE = 16'h0080;
  localparam logic [15:0] HALF_LINE = 16'h0040;
  // request tags carried with a first miss fetch
  localparam logic [1:0] TAG_NONE = 2'h0;
  localparam logic [1:0] TAG_RD_MISS = 2'h1;
  localparam logic [1:0] TAG_WR_MISS = 2'h2;
  // ==========================================================
  // types
  typedef enum {W_IDLE, W_PREWR, W_ACK, W_READ, W_XFER} tcq_ws_type;
  typedef enum {M_IDLE, M_EVICT, M_FIRST, M_SECOND} tcq_miss_type;
  function automatic logic [15:0] tcq_burst_of(input logic [1:0] p);
    unique case (p)
      P_L2: tcq_burst_of = BURST_L2;
      P_SERIAL: tcq_burst_of = BURST_SERIAL;
      P_HOST: tcq_burst_of = BURST_HOST;
      P_EXTMEM: tcq_burst_of = BURST_EXTMEM;
    endcase
  endfunction
  function automatic logic [1:0] tcq_first(input logic [NQ-1:0] v);
    tcq_first = v[0] ? Q_URGENT : (v[1] ? Q_HIGH : Q_LOW);
  endfunction
endpackage

/* test/tcq_port_model.sv */
// partner model: destination acknowledges and per-port read buses
// assumes command pulses from the crossbar last one sys_clk cycle
`timescale 1ns/1ps
`default_nettype none
module tcq_port_model
  import tcq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic pw_valid,
  input wire logic [1:0] pw_queue,
  output logic ack_valid,
  output logic [1:0] ack_queue,
  input wire logic rc_valid,
  input wire logic [1:0] rc_port,
  input wire logic [31:0] rc_addr,
  input wire logic [15:0] rc_len,
  input wire logic [1:0] rc_queue,
  output logic [NP-1:0] rd_valid,
  input wire logic [NP-1:0] rd_ready,
  output logic [NP-1:0][31:0] rd_data,
  output logic [NP-1:0][1:0] rd_queue
);
  logic [1:0] pend[$];
  logic [33:0] beats[NP][$];
  int wait_n;
  logic phase;
  // ==========================================================
  // acknowledge
  initial begin
    ack_valid = 1'b0;
    ack_queue = 2'h0;
    rd_valid = '0;
    rd_data = '0;
    rd_queue = '0;
    wait_n = 1;
    phase = 1'b0;
  end
  // at most one ack every second cycle; slow mode models a nearly full receive buffer
  always @(posedge sys_clk) begin
    ack_valid <= 1'b0;
    if (!resetn) begin
      pend.delete();
      wait_n = 1;
    end else begin
      if (pw_valid) pend.push_back(pw_queue);
      if (pend.size() == 0) wait_n = slow ? 6 : 1;
      else if (wait_n > 0) wait_n--;
      else begin
        ack_valid <= 1'b1;
        ack_queue <= pend.pop_front();
        wait_n = slow ? 6 : 1;
      end
    end
  end
  // ==========================================================
  // read buses: each beat's data is its own source address
  always @(posedge sys_clk) begin
    if (!resetn) begin
      for (int p = 0; p < NP; p++) beats[p].delete();
    end else begin
      for (int p = 0; p < NP; p++)
        if (rd_valid[p] && rd_ready[p]) void'(beats[p].pop_front());
      if (rc_valid)
        for (int i = 0; i < rc_len; i++)
          beats[rc_port].push_back({rc_queue, rc_addr + 32'(4 * i)});
    end
    phase = ~phase;
    // idle lines toggle so stale data never looks valid
    for (int p = 0; p < NP; p++) begin
      if (beats[p].size() > 0 && !(slow && phase)) begin
        rd_valid[p] <= 1'b1;
        rd_data[p] <= beats[p][0][31:0];
        rd_queue[p] <= beats[p][0][33:32];
      end else begin
        rd_valid[p] <= 1'b0;
        rd_data[p] <= ~rd_data[p];
      end
    end
  end
endmodule
`default_nettype wire

/* test/transfer_crossbar_queues_tb.sv */
// testbench for the transfer crossbar with its partner port model
// assumes tcq_pkg and the crossbar sources are compiled first
`timescale 1ns/1ps
`default_nettype none
module transfer_crossbar_queues_tb
  import tcq_pkg::*;
;
  logic sys_clk, resetn, slow, token_held;
  logic chain_valid, chain_ready, chain_src_incr, chain_dst_incr;
  logic [1:0] chain_prio;
  logic [31:0] chain_src, chain_dst;
  logic [15:0] chain_count;
  logic miss_valid, miss_ready, miss_write, miss_dirty, miss_sram;
  logic miss_program, cpu_release, write_merge;
  logic [31:0] miss_addr, miss_l2_addr, miss_evict_addr;
  logic pw_valid, ack_valid, rc_valid, wr_valid, wr_last, xfer_done;
  logic [1:0] pw_port, pw_queue, ack_queue, rc_port, rc_queue;
  logic [1:0] wr_port, wr_queue, xfer_done_queue;
  logic [31:0] pw_addr, rc_addr, wr_addr, wr_data;
  logic [15:0] pw_len, rc_len;
  logic [NP-1:0] rd_valid, rd_ready;
  logic [NP-1:0][31:0] rd_data;
  logic [NP-1:0][1:0] rd_queue;
  logic [31:0] wa[$], wd[$], pa[$];
  logic [1:0] wq[$], wp[$];
  logic wl[$];
  logic [15:0] pl[$];
  int dn[$];
  int bc[NQ];
  logic [NQ-1:0] acked;
  int rel, mrg, err_count, compares;

  tcq_crossbar #(.DEPTH(4)) uut (.sys_clk(sys_clk), .resetn(resetn),
    .chain_valid(chain_valid), .chain_ready(chain_ready),
    .token_held(token_held), .chain_prio(chain_prio),
    .chain_src(chain_src), .chain_dst(chain_dst),
    .chain_count(chain_count), .chain_src_incr(chain_src_incr),
    .chain_dst_incr(chain_dst_incr), .miss_valid(miss_valid),
    .miss_ready(miss_ready), .miss_write(miss_write),
    .miss_dirty(miss_dirty), .miss_sram(miss_sram),
    .miss_program(miss_program), .miss_addr(miss_addr),
    .miss_l2_addr(miss_l2_addr), .miss_evict_addr(miss_evict_addr),
    .cpu_release(cpu_release), .write_merge(write_merge),
    .pw_valid(pw_valid), .pw_port(pw_port), .pw_addr(pw_addr),
    .pw_len(pw_len), .pw_queue(pw_queue), .ack_valid(ack_valid),
    .ack_queue(ack_queue), .rc_valid(rc_valid), .rc_port(rc_port),
    .rc_addr(rc_addr), .rc_len(rc_len), .rc_queue(rc_queue),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .rd_queue(rd_queue), .wr_valid(wr_valid), .wr_port(wr_port),
    .wr_addr(wr_addr), .wr_data(wr_data), .wr_queue(wr_queue),
    .wr_last(wr_last), .xfer_done(xfer_done),
    .xfer_done_queue(xfer_done_queue));

  tcq_port_model model (.sys_clk(sys_clk), .resetn(resetn), .slow(slow),
    .pw_valid(pw_valid), .pw_queue(pw_queue), .ack_valid(ack_valid),
    .ack_queue(ack_queue), .rc_valid(rc_valid), .rc_port(rc_port),
    .rc_addr(rc_addr), .rc_len(rc_len), .rc_queue(rc_queue),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
    .rd_queue(rd_queue));

  // ==========================================================
  // clock and bus monitor
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // logs the write bus; a read command without its ack is an error
  // sampled on the falling edge, where registered outputs are settled
  always @(negedge sys_clk) begin
    if (resetn) begin
      if (wr_valid) begin
        wa.push_back(wr_addr);
        wp.push_back(wr_port);
        wd.push_back(wr_data);
        wq.push_back(wr_queue);
        wl.push_back(wr_last);
        bc[wr_queue]++;
      end
      if (pw_valid) begin
        pl.push_back(pw_len);
        pa.push_back(pw_addr);
      end
      if (ack_valid) acked[ack_queue] = 1'b1;
      if (rc_valid) begin
        compares++;
        if (acked[rc_queue] !== 1'b1) begin
          err_count++;
          $display("unexpected read command: expected 1 seen 0");
        end
        acked[rc_queue] = 1'b0;
      end
      if (xfer_done) begin
        dn.push_back(bc[xfer_done_queue]);
        bc[xfer_done_queue] = 0;
      end
      if (cpu_release) rel++;
      if (write_merge) mrg++;
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", nm, exp, got);
    end
  endtask
  // burst limits per port; second-level memory is unlimited
  function automatic logic [15:0] blen(input logic [1:0] p);
    case (p)
      P_SERIAL: blen = 16'h0001;
      P_HOST, P_EXTMEM: blen = 16'h0004;
      default: blen = 16'hFFFF;
    endcase
  endfunction
  task automatic clr();
    wa.delete(); wd.delete(); wq.delete(); wl.delete();
    pl.delete(); dn.delete(); wp.delete(); pa.delete();
    rel = 0;
    mrg = 0;
  endtask
  task automatic send(input logic [1:0] pr, input logic [31:0] s, d,
                      input logic [15:0] n);
    // an edge in between keeps back-to-back calls from lowering and
    // raising chain_valid in one time step
    @(posedge sys_clk);
    #1 chain_prio = pr; chain_src = s; chain_dst = d; chain_count = n;
    chain_valid = 1'b1;
    do @(negedge sys_clk); while (chain_ready !== 1'b1);
    @(posedge sys_clk);
    #1 chain_valid = 1'b0;
  endtask
  task automatic take_miss(input logic w, dy, sr, pg,
                           input logic [31:0] a, l, e);
    miss_write = w; miss_dirty = dy; miss_sram = sr; miss_program = pg;
    miss_addr = a; miss_l2_addr = l; miss_evict_addr = e;
    miss_valid = 1'b1;
    do @(negedge sys_clk); while (miss_ready !== 1'b1);
    @(posedge sys_clk);
    #1 miss_valid = 1'b0;
  endtask
  // bounded wait for a number of finished requests
  task automatic wait_done(input int n);
    for (int i = 0; i < 4000 && dn.size() < n; i++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    #1 chk("finished requests", 32'(n), 32'(dn.size()));
  endtask

  // ==========================================================
  // scenarios
  // one channel transfer: bursts, addresses, data, last and queue
  task automatic xfer(input logic [1:0] pr, input logic [31:0] s, d,
                      input logic [15:0] n);
    logic [15:0] b, r, e;
    int pk;
    clr();
    send(pr, s, d, n);
    wait_done(1);
    b = blen(s[31:30]) < blen(d[31:30]) ? blen(s[31:30]) : blen(d[31:30]);
    r = n;
    pk = 0;
    while (r > 0) begin
      e = r < b ? r : b;
      chk("burst length", {16'h0, e}, {16'h0, pl[pk]});
      r = r - e;
      pk++;
    end
    for (int k = 0; k < n; k++) begin
      chk("write address", d + 32'(4 * k), wa[k]);
      chk("write port", {30'h0, d[31:30]}, {30'h0, wp[k]});
      chk("write data", s + 32'(4 * k), wd[k]);
      chk("write queue", {30'h0, pr == 2'h3 ? Q_LOW : pr}, {30'h0, wq[k]});
      chk("last flag", {31'h0, (k + 1) % b == 0 || k == n - 1}, {31'h0, wl[k]});
    end
    chk("done beats", {16'h0, n}, 32'(dn[0]));
    chk("pre-write address", d, pa[0]);
  endtask
  // two queues in flight on different ports
  task automatic concurrent();
    clr();
    send(Q_HIGH, 32'hC000_0300, 32'h8000_0040, 16'h0008);
    send(Q_LOW, 32'h0000_0600, 32'h4000_0020, 16'h0002);
    wait_done(2);
    chk("beats total", 32'h0000_000A, 32'(wa.size()));
  endtask
  // read miss in the second quarter, clean victim
  task automatic miss_read();
    clr();
    take_miss(1'b0, 1'b0, 1'b0, 1'b0, 32'hC000_0020, 32'h0000_1000,
              32'hC800_0000);
    wait_done(2);
    chk("first size", 32'h0000_0018, 32'(dn[0]));
    chk("second size", 32'h0000_0008, 32'(dn[1]));
    chk("first address", 32'h0000_1020, wa[0]);
    chk("first data", 32'hC000_0020, wd[0]);
    chk("second address", 32'h0000_1000, wa[24]);
    chk("miss queue", {30'h0, Q_URGENT}, {30'h0, wq[0]});
    chk("release count", 32'h1, 32'(rel));
    chk("merge count", 32'h0, 32'(mrg));
  endtask
  // write miss in the fourth quarter with a dirty victim
  task automatic miss_dirty_write();
    clr();
    take_miss(1'b1, 1'b1, 1'b0, 1'b0, 32'hC000_0460, 32'h0000_2000,
              32'hC100_0080);
    wait_done(3);
    chk("evict size", 32'h0000_0020, 32'(dn[0]));
    chk("evict address", 32'hC100_0080, wa[0]);
    chk("evict data", 32'h0000_2000, wd[0]);
    chk("first size", 32'h0000_0008, 32'(dn[1]));
    chk("first address", 32'h0000_2060, wa[32]);
    chk("second size", 32'h0000_0018, 32'(dn[2]));
    chk("merge count", 32'h1, 32'(mrg));
  endtask
  // all-SRAM program miss: one unsplit line
  task automatic miss_sram_prog();
    clr();
    take_miss(1'b0, 1'b0, 1'b1, 1'b1, 32'hC000_0820, 32'h0000_3000,
              32'hC800_0000);
    wait_done(1);
    chk("line size", 32'h0000_0040, 32'(dn[0]));
    chk("line address", 32'h0000_3000, wa[0]);
    chk("line data", 32'hC000_0800, wd[0]);
    chk("release count", 32'h1, 32'(rel));
  endtask
  // chain and cache contend for the urgent queue; the token decides
  task automatic token_order();
    clr();
    token_held = 1'b1;
    take_miss(1'b0, 1'b0, 1'b0, 1'b0, 32'hC000_0000, 32'h0000_4000,
              32'hC800_0000);
    send(Q_URGENT, 32'h0000_0800, 32'h4000_0000, 16'h0001);
    token_held = 1'b0;
    wait_done(3);
    chk("second in queue", 32'h0000_0010, 32'(dn[1]));
    chk("third in queue", 32'h0000_0001, 32'(dn[2]));
  endtask

  // ==========================================================
  // closing, watchdog and main sequence
  task automatic finish_test();
    $display("errors %0d comparisons %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // roughly fifty times the expected run length
  initial begin
    #200000;
    err_count++;
    $display("unexpected run length: expected end seen timeout");
    finish_test();
  end
  initial begin
    err_count = 0; compares = 0; rel = 0; mrg = 0; acked = '0;
    bc = '{default: 0};
    resetn = 1'b0; slow = 1'b0; token_held = 1'b0;
    chain_valid = 1'b0; chain_prio = 2'h0; chain_src = 32'h0;
    chain_dst = 32'h0; chain_count = 16'h0;
    chain_src_incr = 1'b1; chain_dst_incr = 1'b1;
    miss_valid = 1'b0; miss_write = 1'b0; miss_dirty = 1'b0;
    miss_sram = 1'b0; miss_program = 1'b0; miss_addr = 32'h0;
    miss_l2_addr = 32'h0; miss_evict_addr = 32'h0;
    repeat (16) @(posedge sys_clk);
    #1 resetn = 1'b1;
    xfer(Q_HIGH, 32'hC000_0100, 32'h8000_0000, 16'h0006);
    slow = 1'b1;
    xfer(2'h3, 32'h0000_0200, 32'h4000_0010, 16'h0002);
    slow = 1'b0;
    xfer(Q_URGENT, 32'h0000_0400, 32'hC000_0800, 16'h0003);
    xfer(Q_LOW, 32'h0000_0A00, 32'h0000_0E00, 16'h0020);
    concurrent();
    miss_read();
    miss_dirty_write();
    miss_sram_prog();
    token_order();
    finish_test();
  end
endmodule
`default_nettype wire
